// ==== logic/eec_pkg.sv ====
// Purpose: Constants and types for the external edge counter with compare A
// Assumes: Byte-wide register port, 16-bit registers split into high and low bytes
// Notes: Offsets are byte addresses within the timer window
package eec_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [15:0] OFS_CLOCK_CLEAR = 16'hF700;
    localparam logic [15:0] OFS_COMPARE_IO = 16'hF701;
    localparam logic [15:0] OFS_IRQ_ENABLE = 16'hF702;
    localparam logic [15:0] OFS_FLAG_STATUS = 16'hF703;
    localparam logic [15:0] OFS_COUNT_HI = 16'hF706;
    localparam logic [15:0] OFS_COUNT_LO = 16'hF707;
    localparam logic [15:0] OFS_COMPARE_HI = 16'hF708;
    localparam logic [15:0] OFS_COMPARE_LO = 16'hF709;
    localparam logic [15:0] OFS_RUN_CONTROL = 16'hF720;
    localparam logic [15:0] OFS_PAIRING_MODE = 16'hF721;
    localparam logic [15:0] OFS_FUNC_CONTROL = 16'hF723;
    localparam logic [15:0] OFS_OUTPUT_ENABLE = 16'hF724;
    localparam logic [15:0] OFS_IRQ_MASK = 16'hF728;

    // ==========================================================
    // Field positions
    localparam int CLR_LSB = 5;
    localparam int EDGE_LSB = 3;
    localparam int PRESCALE_EXT_BIT = 2;
    localparam int IOA_TOP_BIT = 2;
    localparam int MATCH_BIT = 0;
    localparam int RUN0_BIT = 0;
    localparam int RUN1_BIT = 1;
    localparam int LOCKSTEP_BIT = 0;
    localparam int EXT_GATE_BIT = 6;
    localparam int MASK_A0_BIT = 0;

    // ==========================================================
    // Encodings and reset values
    localparam logic [2:0] CLR_ON_COMPARE_A = 3'h1;
    localparam logic [1:0] EDGE_RISING = 2'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_OUTPUT_ENABLE = 8'hFF;
    localparam logic [7:0] RST_IRQ_MASK = 8'h01;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_COMPARE = 16'hFFFF;

    // ==========================================================
    // Bus carrier
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } eec_bus_req_type;

endpackage

// ==== logic/eec_counter.sv ====
// Purpose: Channel 0 event counter with compare register A and match interrupt
// Assumes: Pin input synchronous to MCLK_IN; rising edges detected by sampling
// Notes: Channel 1 counter is a plain run/stop counter kept for lockstep start
//
// Function
// - Counter zero: sixteen-bit readable writable up-counter
// - External source counts rising pin edges
// - Prescale bit two selects external clock
// - Edge select zero counts rising edges
// - Clear select 001 clears on compare A
// - Io control 000: compare mode, no pin drive
// - Compare always; equal sets match flag; code compares only at counting ticks while counter zero runs
// - Flag and enable raise CPU interrupt
// - Enable gating applies in output-compare mode
// - Run bit starts and stops counters
// - Lockstep zero: counters run independently
// - Output master enable gates channel pins
// - External gate bit admits external clock
// - Output mask one disables pin drive
// - Lockstep one: counters run synchronously
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module eec_counter
    import eec_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // Register port
    input wire eec_pkg::eec_bus_req_type BUS_REQ_IN,
    output logic [7:0] BUS_RDATA_OUT,
    // Internal count clock tick
    input wire logic INT_TICK_IN,
    // Counter pin
    input wire logic EXT_CLOCK_PIN_IN,
    output logic EXT_CLOCK_PIN_OUT,
    output logic EXT_CLOCK_PIN_OE_OUT,
    // Interrupt
    output logic IRQ_OUT
);
    import eec_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0] clock_clear_r;
    logic [7:0] compare_io_r;
    logic [7:0] irq_enable_r;
    logic [7:0] irq_mask_r;
    logic [7:0] run_control_r;
    logic [7:0] pairing_mode_r;
    logic [7:0] func_control_r;
    logic [7:0] output_enable_r;
    logic [15:0] counter_zero_r;
    logic [15:0] counter_one_r;
    logic [15:0] compare_reg_a_r;
    logic match_flag_a_r;
    logic pin_out_r;
    logic pin_prev_r;
    logic [7:0] rdata_r;
    logic [15:0] counter_zero_nxt;

    logic wr;
    logic ext_selected;
    logic ext_rise;
    logic count_tick;
    logic run0;
    logic run1;
    logic compare_hit;
    logic clear_on_a;
    logic flag_clear;
    logic match_event;
    logic irq_gate;

    // Address selects, one per byte register
    logic sel_clock_clear;
    logic sel_compare_io;
    logic sel_irq_enable;
    logic sel_flag_status;
    logic sel_count_hi;
    logic sel_count_lo;
    logic sel_compare_hi;
    logic sel_compare_lo;
    logic sel_run_control;
    logic sel_pairing_mode;
    logic sel_func_control;
    logic sel_output_enable;
    logic sel_irq_mask;

    assign wr = BUS_REQ_IN.wr;

    // ==========================================================
    // Address decode
    assign sel_clock_clear = BUS_REQ_IN.addr == OFS_CLOCK_CLEAR;
    assign sel_compare_io = BUS_REQ_IN.addr == OFS_COMPARE_IO;
    assign sel_irq_enable = BUS_REQ_IN.addr == OFS_IRQ_ENABLE;
    assign sel_flag_status = BUS_REQ_IN.addr == OFS_FLAG_STATUS;
    assign sel_count_hi = BUS_REQ_IN.addr == OFS_COUNT_HI;
    assign sel_count_lo = BUS_REQ_IN.addr == OFS_COUNT_LO;
    assign sel_compare_hi = BUS_REQ_IN.addr == OFS_COMPARE_HI;
    assign sel_compare_lo = BUS_REQ_IN.addr == OFS_COMPARE_LO;
    assign sel_run_control = BUS_REQ_IN.addr == OFS_RUN_CONTROL;
    assign sel_pairing_mode = BUS_REQ_IN.addr == OFS_PAIRING_MODE;
    assign sel_func_control = BUS_REQ_IN.addr == OFS_FUNC_CONTROL;
    assign sel_output_enable = BUS_REQ_IN.addr == OFS_OUTPUT_ENABLE;
    assign sel_irq_mask = BUS_REQ_IN.addr == OFS_IRQ_MASK;

    // ==========================================================
    // Control registers
    // Clock source, edge and clear select
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            clock_clear_r <= RST_BYTE;
        end else if (wr && sel_clock_clear) begin
            clock_clear_r <= BUS_REQ_IN.wdata;
        end
    end

    // Compare A pin action and mode
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            compare_io_r <= RST_BYTE;
        end else if (wr && sel_compare_io) begin
            compare_io_r <= BUS_REQ_IN.wdata;
        end
    end

    // Match interrupt enable
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            irq_enable_r <= RST_BYTE;
        end else if (wr && sel_irq_enable) begin
            irq_enable_r <= BUS_REQ_IN.wdata;
        end
    end

    // Interrupt mask, same layout as status
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            irq_mask_r <= RST_IRQ_MASK;
        end else if (wr && sel_irq_mask) begin
            irq_mask_r <= BUS_REQ_IN.wdata;
        end
    end

    // Run bits for both counters
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            run_control_r <= RST_BYTE;
        end else if (wr && sel_run_control) begin
            run_control_r <= BUS_REQ_IN.wdata;
        end
    end

    // Independent or lockstep operation
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pairing_mode_r <= RST_BYTE;
        end else if (wr && sel_pairing_mode) begin
            pairing_mode_r <= BUS_REQ_IN.wdata;
        end
    end

    // External clock gate and channel modes
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            func_control_r <= RST_BYTE;
        end else if (wr && sel_func_control) begin
            func_control_r <= BUS_REQ_IN.wdata;
        end
    end

    // Pin output masks, all masked after reset
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            output_enable_r <= RST_OUTPUT_ENABLE;
        end else if (wr && sel_output_enable) begin
            output_enable_r <= BUS_REQ_IN.wdata;
        end
    end

    // ==========================================================
    // Compare register A
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            compare_reg_a_r <= RST_COMPARE;
        end else if (wr && BUS_REQ_IN.addr == OFS_COMPARE_HI) begin
            compare_reg_a_r[15:8] <= BUS_REQ_IN.wdata;
        end else if (wr && BUS_REQ_IN.addr == OFS_COMPARE_LO) begin
            compare_reg_a_r[7:0] <= BUS_REQ_IN.wdata;
        end
    end

    // ==========================================================
    // Clock source selection and edge detect
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= EXT_CLOCK_PIN_IN;
        end
    end

    assign ext_selected = clock_clear_r[PRESCALE_EXT_BIT];
    // Rising pin edge, admitted only while the gate bit is set
    assign ext_rise = EXT_CLOCK_PIN_IN && !pin_prev_r
        && func_control_r[EXT_GATE_BIT];

    always_comb begin
        count_tick = 1'b0;
        // Only the rising-edge setting is implemented; other edges hold
        if (clock_clear_r[EDGE_LSB +: 2] == EDGE_RISING) begin
            count_tick = ext_selected ? ext_rise : INT_TICK_IN;
        end
    end

    // Lockstep: setting either run bit starts both counters; both stop only once both run bits are clear
    assign run0 = run_control_r[RUN0_BIT]
        || (pairing_mode_r[LOCKSTEP_BIT] && run_control_r[RUN1_BIT]);
    assign run1 = run_control_r[RUN1_BIT]
        || (pairing_mode_r[LOCKSTEP_BIT] && run_control_r[RUN0_BIT]);

    // ==========================================================
    // Counter zero
    assign compare_hit = counter_zero_r == compare_reg_a_r;
    assign clear_on_a = clock_clear_r[CLR_LSB +: 3] == CLR_ON_COMPARE_A;

    always_comb begin
        counter_zero_nxt = counter_zero_r;
        if (run0 && count_tick) begin
            if (compare_hit && clear_on_a) begin
                counter_zero_nxt = RST_COUNT;
            end else begin
                counter_zero_nxt = counter_zero_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            counter_zero_r <= RST_COUNT;
        end else if (wr && BUS_REQ_IN.addr == OFS_COUNT_HI) begin
            counter_zero_r[15:8] <= BUS_REQ_IN.wdata;
        end else if (wr && BUS_REQ_IN.addr == OFS_COUNT_LO) begin
            counter_zero_r[7:0] <= BUS_REQ_IN.wdata;
        end else begin
            counter_zero_r <= counter_zero_nxt;
        end
    end

    // Counter one runs on the internal tick in lockstep or on its own
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            counter_one_r <= RST_COUNT;
        end else if (run1 && INT_TICK_IN) begin
            counter_one_r <= counter_one_r + 16'h0001;
        end
    end

    // ==========================================================
    // Match flag: set wins over clear by writing one
    assign flag_clear = wr && sel_flag_status
        && BUS_REQ_IN.wdata[MATCH_BIT];

    // Match seen at a counting tick
    assign match_event = compare_hit && run0 && count_tick;

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            match_flag_a_r <= 1'b0;
        end else if (match_event) begin
            match_flag_a_r <= 1'b1;
        end else if (flag_clear) begin
            match_flag_a_r <= 1'b0;
        end
    end

    // Interrupt in output-compare mode only, gated by enable and mask
    assign irq_gate = irq_enable_r[MATCH_BIT] && irq_mask_r[MATCH_BIT]
        && !compare_io_r[IOA_TOP_BIT];
    assign IRQ_OUT = match_flag_a_r && irq_gate;

    // ==========================================================
    // Pin output: compare output disabled with io control 000
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pin_out_r <= 1'b0;
        end else if (match_event) begin
            case (compare_io_r[1:0])
                2'h1: begin
                    pin_out_r <= 1'b0;
                end
                2'h2: begin
                    pin_out_r <= 1'b1;
                end
                2'h3: begin
                    pin_out_r <= !pin_out_r;
                end
                default: begin
                    pin_out_r <= pin_out_r;
                end
            endcase
        end
    end

    assign EXT_CLOCK_PIN_OUT = pin_out_r;
    assign EXT_CLOCK_PIN_OE_OUT = !output_enable_r[MASK_A0_BIT]
        && !compare_io_r[IOA_TOP_BIT] && (compare_io_r[1:0] != 2'h0)
        && !ext_selected;

    // ==========================================================
    // Read port
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            rdata_r <= RST_BYTE;
        end else if (BUS_REQ_IN.rd) begin
            // Unmapped addresses read as zero
            case (BUS_REQ_IN.addr)
                OFS_CLOCK_CLEAR: begin
                    rdata_r <= clock_clear_r;
                end
                OFS_COMPARE_IO: begin
                    rdata_r <= compare_io_r;
                end
                OFS_IRQ_ENABLE: begin
                    rdata_r <= irq_enable_r;
                end
                OFS_IRQ_MASK: begin
                    rdata_r <= irq_mask_r;
                end
                OFS_FLAG_STATUS: begin
                    rdata_r <= {7'h00, match_flag_a_r};
                end
                OFS_COUNT_HI: begin
                    rdata_r <= counter_zero_r[15:8];
                end
                OFS_COUNT_LO: begin
                    rdata_r <= counter_zero_r[7:0];
                end
                OFS_COMPARE_HI: begin
                    rdata_r <= compare_reg_a_r[15:8];
                end
                OFS_COMPARE_LO: begin
                    rdata_r <= compare_reg_a_r[7:0];
                end
                OFS_RUN_CONTROL: begin
                    rdata_r <= run_control_r;
                end
                OFS_PAIRING_MODE: begin
                    rdata_r <= pairing_mode_r;
                end
                OFS_FUNC_CONTROL: begin
                    rdata_r <= func_control_r;
                end
                OFS_OUTPUT_ENABLE: begin
                    rdata_r <= output_enable_r;
                end
                default: begin
                    rdata_r <= RST_BYTE;
                end
            endcase
        end else begin
            rdata_r <= RST_BYTE;
        end
    end

    assign BUS_RDATA_OUT = rdata_r;

endmodule

`default_nettype wire

// ==== tb/eec_counter_sva.sv ====
// Purpose: Port-level checks for the channel 0 edge counter
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to eec_counter after the module
`timescale 1ns/1ps
`default_nettype none
module eec_counter_sva
    import eec_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // Register port and outputs
    input wire eec_pkg::eec_bus_req_type BUS_REQ_IN,
    input wire logic [7:0] BUS_RDATA_OUT,
    input wire logic EXT_CLOCK_PIN_OE_OUT,
    input wire logic IRQ_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // ==========================================================
    // Control register write then read back
    sequence s_ctrl_wr;
        BUS_REQ_IN.wr && BUS_REQ_IN.addr == OFS_CLOCK_CLEAR;
    endsequence
    sequence s_ctrl_rd;
        BUS_REQ_IN.rd && BUS_REQ_IN.addr == OFS_CLOCK_CLEAR;
    endsequence
    // ==========================================================
    // Assertions
    chk_rdata_idle:
    assert property (!BUS_REQ_IN.rd |=> BUS_RDATA_OUT == 8'h00)
        else $error("read data not zero outside read slot");
    chk_unmapped_zero:
    assert property (BUS_REQ_IN.rd && BUS_REQ_IN.addr == 16'hF704 |=> BUS_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_readback:
    assert property (s_ctrl_wr ##2 s_ctrl_rd |=> BUS_RDATA_OUT == $past(BUS_REQ_IN.wdata, 3))
        else $error("control byte read back wrong");
    chk_flag_reads_set:
    assert property (BUS_REQ_IN.rd && BUS_REQ_IN.addr == OFS_FLAG_STATUS && IRQ_OUT
        |=> BUS_RDATA_OUT[MATCH_BIT])
        else $error("interrupt high but match flag reads zero");
    chk_irq_sticky:
    assert property (IRQ_OUT && !BUS_REQ_IN.wr |=> IRQ_OUT)
        else $error("interrupt dropped without a write");
    chk_irq_enable_off:
    assert property (BUS_REQ_IN.wr && BUS_REQ_IN.addr == OFS_IRQ_ENABLE && !BUS_REQ_IN.wdata[0]
        |=> !IRQ_OUT)
        else $error("interrupt high with enable cleared");
    chk_irq_out_mode:
    assert property (BUS_REQ_IN.wr && BUS_REQ_IN.addr == OFS_COMPARE_IO
        && BUS_REQ_IN.wdata[IOA_TOP_BIT] |=> !IRQ_OUT)
        else $error("interrupt high outside compare mode");
    chk_oe_by_write:
    assert property ($changed(EXT_CLOCK_PIN_OE_OUT) |-> $past(BUS_REQ_IN.wr))
        else $error("pin drive changed without a write");
endmodule
bind eec_counter eec_counter_sva eec_counter_sva_i (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .BUS_REQ_IN(BUS_REQ_IN), .BUS_RDATA_OUT(BUS_RDATA_OUT),
    .EXT_CLOCK_PIN_OE_OUT(EXT_CLOCK_PIN_OE_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ==== tb/eec_ext_clock_src.sv ====
// Purpose: External clock source feeding the counter pin
// Assumes: Levels change just after MCLK_IN rising edges
// Notes: Rests low whenever stopped
`timescale 1ns/1ps
`default_nettype none
module eec_ext_clock_src (
    // Clock and control
    input wire logic MCLK_IN,
    input wire logic RUN_IN,
    input wire logic [3:0] HALF_IN,
    // Pin and rising edge tally
    output var logic PIN_OUT,
    output var int EDGES_OUT
);
    int ph = 0;
    initial begin
        PIN_OUT = 1'b0;
        EDGES_OUT = 0;
    end
    // ==========================================================
    // Square wave of HALF_IN cycles per level
    always @(posedge MCLK_IN) begin
        if (!RUN_IN) begin
            PIN_OUT <= 1'b0;
            ph <= 0;
        end else if (ph + 1 >= int'(HALF_IN)) begin
            ph <= 0;
            PIN_OUT <= !PIN_OUT;
            EDGES_OUT <= EDGES_OUT + (PIN_OUT ? 0 : 1);
        end else begin
            ph <= ph + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/eec_counter_tb_top.sv ====
// Purpose: Self-checking bench for the channel 0 edge counter
// Assumes: Internal tick unused, pin fed by the source model
// Notes: Counter outcome modelled per rising edge
`timescale 1ns/1ps
`default_nettype none
module eec_counter_tb_top;
    import eec_pkg::*;
    logic clk, rst, run, pin_src, pin_o, oe, irq;
    logic [3:0] half;
    logic [7:0] rdata;
    eec_bus_req_type bus;
    wire logic pin_lvl;
    int edges, err_count, n_checks;
    logic [15:0] ra [14] = '{16'hF700, 16'hF701, 16'hF702, 16'hF703, 16'hF706, 16'hF707,
        16'hF708, 16'hF709, 16'hF720, 16'hF721, 16'hF723, 16'hF724, 16'hF728, 16'hF704};
    logic [7:0] rv [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h00};
    // Config {clock/clear, run, pairing, function, counts}
    logic [32:0] cfg [8] = '{{32'h24010040, 1'b1}, {32'h20010040, 1'b0},
        {32'h2C010040, 1'b0}, {32'h24010000, 1'b0}, {32'h24000040, 1'b0},
        {32'h24020040, 1'b0}, {32'h24020140, 1'b1}, {32'h27010040, 1'b1}};
    // Interrupt gating {address, data, irq}
    logic [24:0] ig [6] = '{{16'hF702, 8'h00, 1'b0}, {16'hF702, 8'h01, 1'b1},
        {16'hF728, 8'h00, 1'b0}, {16'hF728, 8'h01, 1'b1}, {16'hF701, 8'h04, 1'b0},
        {16'hF701, 8'h00, 1'b1}};
    assign pin_lvl = oe ? pin_o : pin_src;
    eec_counter eec_counter_i (.MCLK_IN(clk), .SYS_RST_IN(rst), .BUS_REQ_IN(bus),
        .BUS_RDATA_OUT(rdata), .INT_TICK_IN(1'b0), .EXT_CLOCK_PIN_IN(pin_lvl),
        .EXT_CLOCK_PIN_OUT(pin_o), .EXT_CLOCK_PIN_OE_OUT(oe), .IRQ_OUT(irq));
    eec_ext_clock_src eec_ext_clock_src_i (.MCLK_IN(clk), .RUN_IN(run), .HALF_IN(half),
        .PIN_OUT(pin_src), .EDGES_OUT(edges));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================================
    // Checks, bus cycles and counting runs
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        check(nm, {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic count_run(input int cmp, input int n, input logic [3:0] h, input bit on);
        int c;
        int base;
        bit f;
        c = 0;
        f = 1'b0;
        wr(16'hF703, 8'h01);
        wr(16'hF706, 8'h00);
        wr(16'hF707, 8'h00);
        wr(16'hF708, cmp[15:8]);
        wr(16'hF709, cmp[7:0]);
        base = edges;
        if (n > 0) begin
            half <= h;
            run <= 1'b1;
            while (edges != base + n) @(posedge clk);
            run <= 1'b0;
        end
        repeat (3) @(posedge clk);
        if (on) repeat (n) if (c == cmp) begin
            f = 1'b1;
            c = 0;
        end else c++;
        rd(16'hF706, c[15:8], "count_hi");
        rd(16'hF707, c[7:0], "count_lo");
        rd(16'hF703, {7'h00, f}, "match_flag");
        check("irq", {15'h0000, f}, {15'h0000, irq});
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        bus = '0;
        run = 1'b0;
        half = 4'h1;
        rst = 1'b1;
        err_count = 0;
        n_checks = 0;
        void'($urandom(32'hAA68887A));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i], "reset_value");
        wr(16'hF704, 8'h5A);
        rd(16'hF704, 8'h00, "unmapped");
        wr(16'hF702, 8'h01);
        wr(16'hF724, 8'h00);
        #1;
        check("pin_drive", 16'h0000, {15'h0000, oe});
        wr(16'hF701, 8'h01);
        #1;
        check("pin_drive_on", 16'h0001, {15'h0000, oe});
        wr(16'hF724, 8'h01);
        #1;
        check("pin_masked", 16'h0000, {15'h0000, oe});
        wr(16'hF724, 8'h00);
        wr(16'hF701, 8'h00);
        foreach (cfg[i]) begin
            wr(16'hF700, cfg[i][32:25]);
            rd(16'hF700, cfg[i][32:25], "clock_clear");
            wr(16'hF720, cfg[i][24:17]);
            wr(16'hF721, cfg[i][16:9]);
            wr(16'hF723, cfg[i][8:1]);
            count_run(16'hFFFF, 3, 4'h2, cfg[i][0]);
        end
        repeat (4) count_run($urandom_range(1, 6), $urandom_range(0, 14), 4'($urandom_range(1, 5)), 1'b1);
        count_run(1024, 1024, 4'h1, 1'b1);
        count_run(1024, 1025, 4'h1, 1'b1);
        wr(16'hF703, 8'h00);
        rd(16'hF703, 8'h01, "flag_kept");
        foreach (ig[i]) begin
            wr(ig[i][24:9], ig[i][8:1]);
            #1;
            check("irq_gate", {15'h0000, ig[i][0]}, {15'h0000, irq});
        end
        wr(16'hF703, 8'h01);
        rd(16'hF703, 8'h00, "flag_cleared");
        check("irq_cleared", 16'h0000, {15'h0000, irq});
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
